/* File: atc_accum.sv */
`timescale 1ns/1ps
module atc_accum
   import atc_pkg::*;
#(
   parameter bit HAS_PERMIT = 1'b1,
   parameter int UNIT_MS    = 1
) (
   // clock and reset
   input  wire logic   core_clk,
   input  wire logic   sys_rst,
   // time base
   input  wire logic   msTick,
   // control and status
   input  atc_acc_ctl_t ctl,
   output atc_acc_sts_t sts
);

   logic [31:0]  subMs_q;
   logic [31:0]  subMs_d;
   atc_acc_sts_t sts_q;
   atc_acc_sts_t sts_d;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire run      = HAS_PERMIT ? ctl.permit : 1'b1;
   wire unitDone = (subMs_q == 32'(UNIT_MS - 1));
   wire atMax    = (sts_q.elapsedTotal == ATC_VAL_MAX);

   // next state
   always_comb begin
      subMs_d = subMs_q;
      sts_d   = sts_q;
      sts_d.outputValidFlag = HAS_PERMIT & run;
      if (!run) begin
         subMs_d = 32'h0000_0000;
         sts_d   = '0;
      end else if (ctl.clearRequest) begin
         subMs_d            = 32'h0000_0000; // clear beats gate
         sts_d.done         = 1'b0;
         sts_d.elapsedTotal = ATC_VAL_RST;
      end else begin
         if (ctl.gate && msTick) begin // frozen while gate low
            if (unitDone) begin
               subMs_d = 32'h0000_0000;
               if (!atMax) // saturate
                  sts_d.elapsedTotal = sts_q.elapsedTotal + 32'h0000_0001;
            end else begin
               subMs_d = subMs_q + 32'h0000_0001;
            end
         end
         sts_d.done = sts_q.done |
                      (sts_d.elapsedTotal >= ctl.presetDuration);
      end
   end

   // state registers
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         subMs_q <= 32'h0000_0000;
         sts_q   <= '0;
      end else begin
         subMs_q <= subMs_d;
         sts_q   <= sts_d;
      end
   end

   assign sts = sts_q;

endmodule : atc_accum

/* File: atc_ctl_model.sv */
`timescale 1ns/1ps
module atc_ctl_model
   import atc_pkg::*;
(
   // clock
   input wire logic                     core_clk,
   // controls toward the block
   output atc_acc_ctl_t [ATC_ACC_N-1:0] accCtl,
   output atc_cnt_ctl_t [ATC_CNT_N-1:0] cntCtl
);
   // all controls idle from time zero
   initial begin
      accCtl = '0;
      cntCtl = '0;
   end

   // set the levels of one counter at a clock edge
   task automatic cnt(input int i, input logic en, clr, pre,
                      input logic [ATC_VAL_W-1:0] pv);
      @(posedge core_clk);
      cntCtl[i].permit         <= en;
      cntCtl[i].clearRequest   <= clr;
      cntCtl[i].preloadRequest <= pre;
      cntCtl[i].presetCount    <= pv;
   endtask : cnt

   // set the levels of one accumulator at a clock edge
   task automatic acc(input int i, input logic en, g, clr,
                      input logic [ATC_VAL_W-1:0] pt);
      @(posedge core_clk);
      accCtl[i].permit         <= en;
      accCtl[i].gate           <= g;
      accCtl[i].clearRequest   <= clr;
      accCtl[i].presetDuration <= pt;
   endtask : acc

   // rising edges, each followed by a low cycle so none merge
   task automatic up(input int i, input int n);
      repeat (n) begin
         @(posedge core_clk);
         cntCtl[i].upPulse <= 1'b1;
         @(posedge core_clk);
         cntCtl[i].upPulse <= 1'b0;
      end
   endtask : up

   // falling edges on the down pulse
   task automatic dn(input int i, input int n);
      repeat (n) begin
         @(posedge core_clk);
         cntCtl[i].downPulse <= 1'b1;
         @(posedge core_clk);
         cntCtl[i].downPulse <= 1'b0;
      end
   endtask : dn
endmodule : atc_ctl_model

/* File: atc_pkg.sv */
package atc_pkg;

   // ------------------------------------------------------------
   // value width and saturation limits
   // ------------------------------------------------------------
   localparam int                    ATC_VAL_W   = 32;
   localparam logic [ATC_VAL_W-1:0]  ATC_VAL_RST = 32'h0000_0000;
   localparam logic [ATC_VAL_W-1:0]  ATC_VAL_MAX = 32'hffff_ffff;

   // ------------------------------------------------------------
   // time base
   // ------------------------------------------------------------
   localparam int ATC_CLK_PERIOD_NS = 8;
   localparam int ATC_NS_PER_MS     = 1000000;
   localparam int ATC_TICK_MS       = 1;
   localparam int ATC_TICK_CYCLES   =
      ATC_TICK_MS * ATC_NS_PER_MS / ATC_CLK_PERIOD_NS;
   localparam int ATC_HOUR_MS       = 3600000;

   // ------------------------------------------------------------
   // instance indices
   // ------------------------------------------------------------
   localparam int ATC_ACC_MS       = 0;  // on_time_accumulator
   localparam int ATC_ACC_MS_RED   = 1;  // reduced_on_time_accumulator
   localparam int ATC_ACC_HOUR     = 2;  // hour_on_time_accumulator
   localparam int ATC_ACC_N        = 3;
   localparam int ATC_CNT_DOWN     = 0;  // down_counter
   localparam int ATC_CNT_DOWN_RED = 1;  // reduced_down_counter
   localparam int ATC_CNT_UPDN     = 2;  // up_down_counter
   localparam int ATC_CNT_UPDN_RED = 3;  // reduced_up_down_counter
   localparam int ATC_CNT_UP       = 4;  // up_counter
   localparam int ATC_CNT_UP_RED   = 5;  // reduced_up_counter
   localparam int ATC_CNT_HELD     = 6;  // enable_held_up_counter
   localparam int ATC_CNT_N        = 7;

   typedef enum {ATC_KIND_DOWN, ATC_KIND_UPDN, ATC_KIND_UP,
                 ATC_KIND_HELD} atc_kind_t;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic                 permit;
      logic                 gate;
      logic                 clearRequest;
      logic [ATC_VAL_W-1:0] presetDuration;
   } atc_acc_ctl_t;

   typedef struct packed {
      logic                 outputValidFlag;
      logic                 done;
      logic [ATC_VAL_W-1:0] elapsedTotal;
   } atc_acc_sts_t;

   typedef struct packed {
      logic                 permit;
      logic                 upPulse;
      logic                 downPulse;
      logic                 clearRequest;
      logic                 preloadRequest;
      logic [ATC_VAL_W-1:0] presetCount;
   } atc_cnt_ctl_t;

   typedef struct packed {
      logic                 outputValidFlag;
      logic                 upperReachedFlag;
      logic                 zeroReachedFlag;
      logic [ATC_VAL_W-1:0] countValue;
   } atc_cnt_sts_t;

   function automatic atc_kind_t atc_kind_of(input int idx);
      atc_kind_t k;
      k = ATC_KIND_HELD;
      if (idx <= ATC_CNT_DOWN_RED) k = ATC_KIND_DOWN;
      else if (idx <= ATC_CNT_UPDN_RED) k = ATC_KIND_UPDN;
      else if (idx <= ATC_CNT_UP_RED) k = ATC_KIND_UP;
      return k;
   endfunction : atc_kind_of

endpackage : atc_pkg

/* File: atc_tick_gen.sv */
`timescale 1ns/1ps
module atc_tick_gen
   import atc_pkg::*;
#(
   parameter int TICK_CYCLES = ATC_TICK_CYCLES
) (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic sys_rst,
   // one-cycle millisecond tick
   output logic      msTick
);

   logic [31:0] div_q;
   logic        tick_q;
   wire         wrap = (div_q == 32'(TICK_CYCLES - 1));

   // ------------------------------------------------------------
   // free-running millisecond divider
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_q  <= 32'h0000_0000;
         tick_q <= 1'b0;
      end else begin
         div_q  <= wrap ? 32'h0000_0000 : div_q + 32'h0000_0001;
         tick_q <= wrap; // one-cycle tick every TICK_CYCLES clocks, one millisecond by default
      end
   end

   assign msTick = tick_q;

endmodule : atc_tick_gen

/* File: atc_timer_counter.sv */
`timescale 1ns/1ps
module atc_timer_counter
   import atc_pkg::*;
#(
   parameter int TICK_CYCLES = ATC_TICK_CYCLES,
   parameter int HOUR_MS     = ATC_HOUR_MS
) (
   // clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     sys_rst,
   // accumulator controls and status
   input  atc_acc_ctl_t [ATC_ACC_N-1:0]  accCtl,
   output atc_acc_sts_t [ATC_ACC_N-1:0]  accSts,
   // counter controls and status
   input  atc_cnt_ctl_t [ATC_CNT_N-1:0]  cntCtl,
   output atc_cnt_sts_t [ATC_CNT_N-1:0]  cntSts
);

   // ------------------------------------------------------------
   // time base
   // ------------------------------------------------------------
   logic msTick;

   // shared millisecond tick for all accumulators
   atc_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) uTick (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .msTick   (msTick)
   );

   // ------------------------------------------------------------
   // accumulators
   // ------------------------------------------------------------

   // millisecond accumulator with run permit
   atc_accum #(
      .HAS_PERMIT (1'b1),
      .UNIT_MS    (1)
   ) uAccMs (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .msTick   (msTick),
      .ctl      (accCtl[ATC_ACC_MS]),
      .sts      (accSts[ATC_ACC_MS])
   );

   // reduced millisecond accumulator, always running
   atc_accum #(
      .HAS_PERMIT (1'b0),
      .UNIT_MS    (1)
   ) uAccMsRed (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .msTick   (msTick),
      .ctl      (accCtl[ATC_ACC_MS_RED]),
      .sts      (accSts[ATC_ACC_MS_RED])
   );

   // hour accumulator: reduced behaviour, hour units
   atc_accum #(
      .HAS_PERMIT (1'b0),
      .UNIT_MS    (HOUR_MS)
   ) uAccHour (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .msTick   (msTick),
      .ctl      (accCtl[ATC_ACC_HOUR]),
      .sts      (accSts[ATC_ACC_HOUR])
   );

   // ------------------------------------------------------------
   // pulse counters
   // ------------------------------------------------------------
   for (genvar g = 0; g < ATC_CNT_N; g++) begin : gCnt
      localparam atc_kind_t KIND    = atc_kind_of(g);
      localparam bit        REDUCED = (g == ATC_CNT_DOWN_RED) ||
                                      (g == ATC_CNT_UPDN_RED) ||
                                      (g == ATC_CNT_UP_RED);
      localparam bit        HAS_EO  = !REDUCED && (g != ATC_CNT_HELD);

      logic                 upPrev_q;
      logic                 downPrev_q;
      atc_cnt_sts_t         sts_q;
      atc_cnt_sts_t         sts_d;
      logic [ATC_VAL_W-1:0] stepUpDn;

      // decode of inputs against the previous sample
      wire                  run    = REDUCED ? 1'b1 : cntCtl[g].permit;
      wire                  rise   = cntCtl[g].upPulse & ~upPrev_q;
      wire                  fall   = ~cntCtl[g].downPulse & downPrev_q;
      wire [ATC_VAL_W-1:0]  cnt    = sts_q.countValue;
      wire [ATC_VAL_W-1:0]  preset = cntCtl[g].presetCount;
      wire                  atMax  = (cnt == ATC_VAL_MAX);
      wire                  atZero = (cnt == ATC_VAL_RST);
      wire [ATC_VAL_W-1:0]  incVal = atMax ? cnt : cnt + 32'h0000_0001;
      wire [ATC_VAL_W-1:0]  decVal = atZero ? cnt : cnt - 32'h0000_0001;
      wire                  belowP = (cnt < preset);

      // up-down step: simultaneous edges cancel, ends saturate
      always_comb begin
         stepUpDn = cnt;
         if (rise && !fall)
            stepUpDn = incVal;
         else if (fall && !rise)
            stepUpDn = decVal;
      end

      // next state per counter kind
      always_comb begin
         sts_d = sts_q;
         sts_d.outputValidFlag = HAS_EO & run;
         case (KIND)
            ATC_KIND_DOWN: begin
               if (!run) begin
                  sts_d.upperReachedFlag = 1'b0;
                  sts_d.zeroReachedFlag  = 1'b0;
                  sts_d.countValue       = preset;
               end else if (cntCtl[g].preloadRequest) begin
                  sts_d.zeroReachedFlag  = 1'b0;
                  sts_d.countValue       = preset;
               end else begin
                  if (rise)
                     sts_d.countValue = decVal; // stops at zero
                  sts_d.zeroReachedFlag = sts_q.zeroReachedFlag |
                     (sts_d.countValue == ATC_VAL_RST);
               end
            end
            ATC_KIND_UPDN: begin
               if (!run) begin
                  sts_d.upperReachedFlag = 1'b0;
                  sts_d.zeroReachedFlag  = 1'b0;
                  sts_d.countValue       = preset;
               end else if (cntCtl[g].preloadRequest) begin
                  sts_d.upperReachedFlag = 1'b1;
                  sts_d.zeroReachedFlag  = 1'b0;
                  sts_d.countValue       = preset;
               end else if (cntCtl[g].clearRequest) begin
                  sts_d.upperReachedFlag = 1'b0;
                  sts_d.zeroReachedFlag  = 1'b1;
                  sts_d.countValue       = ATC_VAL_RST;
               end else begin
                  sts_d.countValue       = stepUpDn;
                  sts_d.upperReachedFlag =
                     (stepUpDn >= preset);
                  sts_d.zeroReachedFlag  =
                     (stepUpDn == ATC_VAL_RST);
               end
            end
            ATC_KIND_UP: begin
               sts_d.zeroReachedFlag = 1'b0;
               if (!run) begin
                  sts_d.upperReachedFlag = 1'b0;
                  sts_d.countValue       = ATC_VAL_RST;
               end else if (cntCtl[g].clearRequest) begin
                  sts_d.upperReachedFlag = 1'b0;
                  sts_d.countValue       = ATC_VAL_RST;
               end else begin
                  if (rise)
                     sts_d.countValue = incVal;
                  sts_d.upperReachedFlag = sts_q.upperReachedFlag |
                     (sts_d.countValue >= preset);
               end
            end
            ATC_KIND_HELD: begin
               sts_d.zeroReachedFlag = 1'b0;
               if (!run) begin
                  sts_d.upperReachedFlag = 1'b0;
                  sts_d.countValue       = ATC_VAL_RST;
               end else begin
                  if (rise && belowP)
                     sts_d.countValue = incVal; // counts up to preset
                  sts_d.upperReachedFlag = sts_q.upperReachedFlag |
                     (sts_d.countValue >= preset);
               end
            end
            default: begin
               sts_d = '0;
            end
         endcase
      end

      // edge samples and counter state
      always_ff @(posedge core_clk or posedge sys_rst) begin
         if (sys_rst) begin
            upPrev_q   <= 1'b0;
            downPrev_q <= 1'b0;
            sts_q      <= '0;
         end else begin
            upPrev_q   <= cntCtl[g].upPulse;
            downPrev_q <= cntCtl[g].downPulse;
            sts_q      <= sts_d;
         end
      end

      assign cntSts[g] = sts_q;
   end

endmodule : atc_timer_counter

/* File: atc_timer_counter_properties.sv */
`timescale 1ns/1ps
module atc_timer_counter_chk
   import atc_pkg::*;
#(
   parameter int TICK_CYCLES = ATC_TICK_CYCLES,
   parameter int HOUR_MS     = ATC_HOUR_MS
) (
   // clock and reset
   input wire logic                     core_clk,
   input wire logic                     sys_rst,
   // watched ports
   input atc_acc_ctl_t [ATC_ACC_N-1:0]  accCtl,
   input atc_acc_sts_t [ATC_ACC_N-1:0]  accSts,
   input atc_cnt_ctl_t [ATC_CNT_N-1:0]  cntCtl,
   input atc_cnt_sts_t [ATC_CNT_N-1:0]  cntSts
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // ----------------------------------------------------------
   // short names for the watched instances
   // ----------------------------------------------------------
   atc_cnt_ctl_t dnC, udC, upC;
   atc_cnt_sts_t dnS, udS, upS;
   atc_acc_ctl_t aC;
   atc_acc_sts_t aS;
   assign dnC = cntCtl[ATC_CNT_DOWN];
   assign dnS = cntSts[ATC_CNT_DOWN];
   assign udC = cntCtl[ATC_CNT_UPDN];
   assign udS = cntSts[ATC_CNT_UPDN];
   assign upC = cntCtl[ATC_CNT_UP];
   assign upS = cntSts[ATC_CNT_UP];
   assign aC  = accCtl[ATC_ACC_MS];
   assign aS  = accSts[ATC_ACC_MS];

   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   chk_up_no_permit: assert property (!upC.permit |=> upS == '0)
      else $error("up counter not zero without permit");
   chk_dn_no_permit: assert property (!dnC.permit |=>
      dnS.countValue == $past(dnC.presetCount) && !dnS.zeroReachedFlag
      && !dnS.outputValidFlag) else $error("down counter not preset");
   chk_dn_preload: assert property (dnC.permit && dnC.preloadRequest |=>
      dnS.countValue == $past(dnC.presetCount) && !dnS.zeroReachedFlag)
      else $error("down preload failed");
   chk_dn_done_zero: assert property (dnS.outputValidFlag
      && dnS.countValue == '0 && $past(dnS.countValue) != '0
      && !$past(dnC.preloadRequest) |-> dnS.zeroReachedFlag)
      else $error("down done missing at zero");
   chk_ud_preload: assert property (udC.permit && udC.preloadRequest |=>
      udS.upperReachedFlag && !udS.zeroReachedFlag
      && udS.countValue == $past(udC.presetCount))
      else $error("up-down preload failed");
   chk_ud_clear: assert property (udC.permit && udC.clearRequest
      && !udC.preloadRequest |=> !udS.upperReachedFlag
      && udS.zeroReachedFlag && udS.countValue == '0)
      else $error("up-down clear failed");
   chk_up_clear: assert property (upC.permit && upC.clearRequest |=>
      upS.countValue == '0 && !upS.upperReachedFlag)
      else $error("up clear failed");
   chk_up_step: assert property (upC.permit && upC.upPulse
      && !$past(upC.upPulse) && !upC.clearRequest
      && upS.countValue != ATC_VAL_MAX
      |=> upS.countValue == $past(upS.countValue) + 32'h1)
      else $error("up counter missed a step");
   chk_acc_clear: assert property (accCtl[ATC_ACC_MS_RED].clearRequest |=>
      accSts[ATC_ACC_MS_RED].elapsedTotal == '0
      && !accSts[ATC_ACC_MS_RED].done) else $error("acc clear failed");
   chk_acc_freeze: assert property (aC.permit && !aC.gate
      && !aC.clearRequest |=> $stable(aS.elapsedTotal))
      else $error("acc total moved without gate");
   chk_acc_no_permit: assert property (!aC.permit |=> aS == '0)
      else $error("acc not zero without permit");

   // main scenarios reached
   cov_dn_done: cover property (dnS.zeroReachedFlag);
   cov_ud_upper: cover property (udS.upperReachedFlag);
   cov_acc_done: cover property (aS.done);
endmodule : atc_timer_counter_chk

bind atc_timer_counter atc_timer_counter_chk #(
   .TICK_CYCLES(TICK_CYCLES),
   .HOUR_MS    (HOUR_MS)
) u_chk (
   .core_clk(core_clk),
   .sys_rst (sys_rst),
   .accCtl  (accCtl),
   .accSts  (accSts),
   .cntCtl  (cntCtl),
   .cntSts  (cntSts)
);

/* File: atc_timer_counter_tb.sv */
`timescale 1ns/1ps
module testbench
   import atc_pkg::*;
;
   logic                         core_clk;
   logic                         sys_rst;
   atc_acc_ctl_t [ATC_ACC_N-1:0] accCtl;
   atc_acc_sts_t [ATC_ACC_N-1:0] accSts;
   atc_cnt_ctl_t [ATC_CNT_N-1:0] cntCtl;
   atc_cnt_sts_t [ATC_CNT_N-1:0] cntSts;
   int                           failures;
   int                           comparisons;
   int                           cycles;

   // 125 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   atc_timer_counter #(.TICK_CYCLES(4), .HOUR_MS(3)) DUT (
      .core_clk(core_clk),
      .sys_rst (sys_rst),
      .accCtl  (accCtl),
      .accSts  (accSts),
      .cntCtl  (cntCtl),
      .cntSts  (cntSts)
   );

   atc_ctl_model m (
      .core_clk(core_clk),
      .accCtl  (accCtl),
      .cntCtl  (cntCtl)
   );

   // --------------------------------------------------------
   // checking helpers
   // --------------------------------------------------------
   task automatic report_and_stop();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop

   // hang guard
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         failures++;
         report_and_stop();
      end
   end

   // let the last request be sampled and its answer land
   task automatic settle();
      repeat (2) @(posedge core_clk);
      #1;
   endtask : settle

   task automatic chkCnt(string nm, int i, logic v, u, z,
                         logic [ATC_VAL_W-1:0] c);
      atc_cnt_sts_t e;
      e = '{v, u, z, c};
      comparisons++;
      if (cntSts[i] !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", nm, e, cntSts[i]);
      end
   endtask : chkCnt

   task automatic chkAcc(string nm, int i, logic v, d,
                         logic [ATC_VAL_W-1:0] t);
      atc_acc_sts_t e;
      e = '{v, d, t};
      comparisons++;
      if (accSts[i] !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", nm, e, accSts[i]);
      end
   endtask : chkAcc

   // wait, bounded, for an accumulator done flag
   task automatic waitDone(int i);
      for (int k = 0; k < 100; k++) begin
         @(posedge core_clk);
         #1;
         if (accSts[i].done === 1'b1) break;
      end
   endtask : waitDone

   // --------------------------------------------------------
   // scenarios
   // --------------------------------------------------------
   task automatic t_counters();
      m.cnt(4, 1, 0, 0, 32'h3);
      m.up(4, 3);
      settle();
      chkCnt("up reach", 4, 1, 1, 0, 32'h3);
      m.up(4, 1);
      settle();
      chkCnt("up sticky", 4, 1, 1, 0, 32'h4);
      m.cnt(4, 1, 1, 0, 32'h3);
      m.up(4, 2);
      settle();
      chkCnt("up clear", 4, 1, 0, 0, 32'h0);
      m.cnt(0, 1, 0, 1, 32'h2);
      settle();
      chkCnt("dn preload", 0, 1, 0, 0, 32'h2);
      m.cnt(0, 1, 0, 0, 32'h2);
      m.up(0, 3);
      settle();
      chkCnt("dn zero", 0, 1, 0, 1, 32'h0);
      m.cnt(0, 0, 0, 0, 32'h5);
      settle();
      chkCnt("dn no permit", 0, 0, 0, 0, 32'h5);
      m.cnt(6, 1, 0, 0, 32'h2);
      m.up(6, 3);
      settle();
      chkCnt("held reach", 6, 0, 1, 0, 32'h2);
      m.cnt(6, 0, 0, 0, 32'h2);
      settle();
      chkCnt("held drop", 6, 0, 0, 0, 32'h0);
      $display("counter test done");
   endtask : t_counters

   task automatic t_updown();
      m.cnt(2, 1, 1, 1, 32'h2);
      settle();
      chkCnt("ud both", 2, 1, 1, 0, 32'h2);
      m.cnt(2, 1, 1, 0, 32'h2);
      m.up(2, 1);
      settle();
      chkCnt("ud clear", 2, 1, 0, 1, 32'h0);
      m.cnt(2, 1, 0, 0, 32'h2);
      m.up(2, 2);
      settle();
      chkCnt("ud up", 2, 1, 1, 0, 32'h2);
      m.dn(2, 1);
      settle();
      chkCnt("ud down", 2, 1, 0, 0, 32'h1);
      m.dn(2, 1);
      settle();
      chkCnt("ud zero", 2, 1, 0, 1, 32'h0);
      m.cnt(2, 0, 0, 0, 32'h7);
      settle();
      chkCnt("ud no permit", 2, 0, 0, 0, 32'h7);
      m.cnt(3, 0, 0, 1, 32'h4);
      settle();
      chkCnt("ud reduced", 3, 0, 1, 0, 32'h4);
      m.cnt(5, 0, 1, 0, 32'h2); // drop the done flag latched since reset
      m.cnt(5, 0, 0, 0, 32'h2);
      m.up(5, 2);
      settle();
      chkCnt("up reduced", 5, 0, 1, 0, 32'h2);
      m.cnt(1, 0, 0, 1, 32'h1);
      m.cnt(1, 0, 0, 0, 32'h1);
      m.up(1, 1);
      settle();
      chkCnt("dn reduced", 1, 0, 0, 1, 32'h0);
      $display("up-down test done");
   endtask : t_updown

   task automatic t_accum();
      m.acc(0, 1, 0, 1, 32'h3);
      m.acc(0, 1, 1, 0, 32'h3);
      waitDone(0);
      chkAcc("acc done", 0, 1, 1, 32'h3);
      m.acc(0, 1, 0, 0, 32'h3);
      repeat (12) @(posedge core_clk);
      #1;
      chkAcc("acc frozen", 0, 1, 1, 32'h3);
      m.acc(0, 1, 1, 1, 32'h3);
      settle();
      chkAcc("acc clear", 0, 1, 0, 32'h0);
      m.acc(0, 0, 1, 0, 32'h3);
      settle();
      chkAcc("acc no permit", 0, 0, 0, 32'h0);
      m.acc(1, 0, 0, 1, 32'h1);
      settle();
      chkAcc("acc reduced", 1, 0, 0, 32'h0);
      m.acc(2, 0, 0, 1, 32'h1); // done latched since reset with preset 0
      m.acc(2, 0, 1, 0, 32'h1);
      waitDone(2);
      chkAcc("acc hour", 2, 0, 1, 32'h1);
      $display("accumulator test done");
   endtask : t_accum

   // main sequence
   initial begin
      failures    = 0;
      comparisons = 0;
      cycles      = 0;
      sys_rst     = 1'b1;
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_counters();
      t_updown();
      t_accum();
      report_and_stop();
   end
endmodule : testbench
